// >>> include/audio_pkg.sv
// constants and types of the audio engine register front end
// Overview of operation
// - any write to the effect trigger starts the selected synthesized effect
// - effect trigger bit 0 reads 1 while an effect plays, else 0
// - effect select holds note in bits 15..8 and effect code in 7..0
// - note byte ignored for effects without pitch, used as pitch otherwise
// - synth volume is 8-bit gain, reset 0xFF loudest, zero mutes
// - playback volume is 8-bit gain, reset 0xFF loudest, zero mutes
// - any write to playback start begins playback, value 0 or 1
// - playback start bit 0 reads 1 while playing, 0 once complete
// - loop bit 1 restarts at start address at end, 0 stops there
// - two-bit format: linear, mu-law, 4-bit ADPCM, code 11 undefined
// - 16-bit sample rate field in hertz, resets to 8000
package audio_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PTR_W  = 20;
  localparam int RATE_W = 16;
  localparam int VOL_W  = 8;
  localparam int SEL_W  = 16;
  localparam int FMT_W  = 2;

  localparam logic [ADDR_W-1:0] OFF_PB_VOL  = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_SYN_VOL = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_SELECT  = 8'h88;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER = 8'h8C;
  localparam logic [ADDR_W-1:0] OFF_START   = 8'hB4;
  localparam logic [ADDR_W-1:0] OFF_LENGTH  = 8'hB8;
  localparam logic [ADDR_W-1:0] OFF_RDPTR   = 8'hBC;
  localparam logic [ADDR_W-1:0] OFF_RATE    = 8'hC0;
  localparam logic [ADDR_W-1:0] OFF_FORMAT  = 8'hC4;
  localparam logic [ADDR_W-1:0] OFF_LOOP    = 8'hC8;
  localparam logic [ADDR_W-1:0] OFF_PLAY    = 8'hCC;

  localparam logic [VOL_W-1:0]  VOL_RST    = 8'hFF;
  localparam logic [RATE_W-1:0] RATE_RST   = 16'h1F40;
  localparam logic [SEL_W-1:0]  SEL_RST    = 16'h0000;
  localparam logic [FMT_W-1:0]  FMT_LINEAR = 2'h0;
  localparam logic [FMT_W-1:0]  FMT_ULAW   = 2'h1;
  localparam logic [FMT_W-1:0]  FMT_ADPCM  = 2'h2;
  localparam logic [PTR_W-1:0]  WORD_BYTES = 20'h00004;
  localparam int NOTE_LSB = 8;
  localparam int CODE_W   = 8;

  typedef enum logic [1:0] {PB_IDLE, PB_FETCH, PB_DRAIN} pb_state_e;
endpackage : audio_pkg

// >>> design/sample_fifo.sv
// sample word FIFO with a registered output stage
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  // status
  output logic                  isEmpty
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [CW-1:0]    count_reg, count_next;
  logic [WIDTH-1:0] outData_reg, outData_next;
  logic             outValid_reg, outValid_next;
  logic             push, pop;

  assign inReady  = count_reg < CW'(DEPTH);
  assign outValid = outValid_reg;
  assign outData  = outData_reg;
  assign isEmpty  = (count_reg == '0) && !outValid_reg;

  always_comb begin
    push          = inValid && inReady;
    pop           = (count_reg != '0) && (!outValid_reg || outReady);
    wrPtr_next    = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next    = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    count_next    = CW'(count_reg + CW'(push) - CW'(pop));
    outData_next  = pop ? store[rdPtr_reg] : outData_reg;
    outValid_next = pop ? 1'b1 : (outReady ? 1'b0 : outValid_reg);
  end

  // storage has no reset; only words counted as held are ever read
  always_ff @(posedge core_clk) begin
    if (inValid && inReady) begin
      store[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      count_reg    <= '0;
      outData_reg  <= '0;
      outValid_reg <= 1'b0;
    end else begin
      wrPtr_reg    <= wrPtr_next;
      rdPtr_reg    <= rdPtr_next;
      count_reg    <= count_next;
      outData_reg  <= outData_next;
      outValid_reg <= outValid_next;
    end
  end
endmodule : sample_fifo

// >>> design/audio_engine_control.sv
// audio engine register front end with APB slave and playback fetch
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module audio_engine_control #(
  parameter logic [7:0] PITCH_LIMIT = 8'h40,
  parameter int         FIFO_DEPTH  = 8
) (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [audio_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [audio_pkg::DATA_W-1:0]   pwdata,
  output logic [audio_pkg::DATA_W-1:0]        prdata,
  output logic                                pready,
  output logic                                pslverr,
  // synthesizer side
  output logic                                effectStart,
  output logic [audio_pkg::CODE_W-1:0]        effectCode,
  output logic [audio_pkg::CODE_W-1:0]        effectNote,
  output logic [audio_pkg::VOL_W-1:0]         synthGain,
  input  wire logic                           synthDone,
  // graphics memory read port
  output logic                                memReq,
  output logic [audio_pkg::PTR_W-1:0]         memAddr,
  input  wire logic                           memAck,
  input  wire logic [audio_pkg::DATA_W-1:0]   memData,
  // playback output stage
  output logic                                sampleValid,
  input  wire logic                           sampleReady,
  output logic [audio_pkg::DATA_W-1:0]        sampleData,
  output logic [audio_pkg::FMT_W-1:0]         sampleFormat,
  output logic [audio_pkg::RATE_W-1:0]        sampleRate,
  output logic [audio_pkg::VOL_W-1:0]         playGain
);
  localparam int AW = audio_pkg::ADDR_W;
  localparam int DW = audio_pkg::DATA_W;
  localparam int PW = audio_pkg::PTR_W;

  // bus and register state
  logic [DW-1:0]                   prdata_reg, prdata_next;
  logic                            pready_reg, pready_next;
  logic                            pslverr_reg, pslverr_next;
  logic [audio_pkg::SEL_W-1:0]     select_reg, select_next;
  logic                            effectBusy_reg, effectBusy_next;
  logic                            effectStart_reg, effectStart_next;
  logic [audio_pkg::CODE_W-1:0]    effectCode_reg, effectCode_next;
  logic [audio_pkg::CODE_W-1:0]    effectNote_reg, effectNote_next;
  logic [audio_pkg::VOL_W-1:0]     synVol_reg, synVol_next;
  logic [audio_pkg::VOL_W-1:0]     pbVol_reg, pbVol_next;
  logic [PW-1:0]                   startAddr_reg, startAddr_next;
  logic [PW-1:0]                   length_reg, length_next;
  logic [PW-1:0]                   readPtr_reg, readPtr_next;
  logic [audio_pkg::RATE_W-1:0]    rate_reg, rate_next;
  logic [audio_pkg::FMT_W-1:0]     format_reg, format_next;
  logic                            loop_reg, loop_next;
  // playback state
  audio_pkg::pb_state_e            state_reg, state_next;
  logic                            memReq_reg, memReq_next;
  logic [PW-1:0]                   memAddr_reg, memAddr_next;
  logic [PW-1:0]                   remain_reg, remain_next;
  // helpers
  logic                            setup, wrAcc, mapped, fifoInReady, fifoEmpty;
  logic                            fetchHit, lastWord;
  logic [DW-1:0]                   readMux;

  assign setup    = psel && !penable;
  assign wrAcc    = psel && penable && pready_reg && pwrite;
  assign fetchHit = memReq_reg && memAck;
  assign lastWord = remain_reg <= audio_pkg::WORD_BYTES;

  always_comb begin
    readMux = '0;
    mapped  = 1'b1;
    unique case (paddr)
      audio_pkg::OFF_PB_VOL:  readMux = DW'(pbVol_reg);
      audio_pkg::OFF_SYN_VOL: readMux = DW'(synVol_reg);
      audio_pkg::OFF_SELECT:  readMux = DW'(select_reg);
      audio_pkg::OFF_TRIGGER: readMux = DW'(effectBusy_reg);
      audio_pkg::OFF_START:   readMux = DW'(startAddr_reg);
      audio_pkg::OFF_LENGTH:  readMux = DW'(length_reg);
      audio_pkg::OFF_RDPTR:   readMux = DW'(readPtr_reg);
      audio_pkg::OFF_RATE:    readMux = DW'(rate_reg);
      audio_pkg::OFF_FORMAT:  readMux = DW'(format_reg);
      audio_pkg::OFF_LOOP:    readMux = DW'(loop_reg);
      audio_pkg::OFF_PLAY:    readMux = DW'(state_reg != audio_pkg::PB_IDLE);
      default:                mapped  = 1'b0;
    endcase
  end

  always_comb begin
    // bus answers one cycle after setup, no wait states
    pready_next      = setup;
    prdata_next      = setup ? readMux : prdata_reg;
    pslverr_next     = setup && !mapped;
    select_next      = select_reg;
    synVol_next      = synVol_reg;
    pbVol_next       = pbVol_reg;
    startAddr_next   = startAddr_reg;
    length_next      = length_reg;
    rate_next        = rate_reg;
    format_next      = format_reg;
    loop_next        = loop_reg;
    effectStart_next = 1'b0;
    effectCode_next  = effectCode_reg;
    effectNote_next  = effectNote_reg;
    // busy ends when the synthesizer is done
    effectBusy_next  = synthDone ? 1'b0 : effectBusy_reg;
    if (wrAcc) begin
      unique case (paddr)
        audio_pkg::OFF_SELECT:  select_next = pwdata[audio_pkg::SEL_W-1:0];
        audio_pkg::OFF_SYN_VOL: synVol_next = pwdata[audio_pkg::VOL_W-1:0];
        audio_pkg::OFF_PB_VOL:  pbVol_next = pwdata[audio_pkg::VOL_W-1:0];
        audio_pkg::OFF_START:   startAddr_next = pwdata[PW-1:0];
        audio_pkg::OFF_LENGTH:  length_next = pwdata[PW-1:0];
        audio_pkg::OFF_RATE:    rate_next = pwdata[audio_pkg::RATE_W-1:0];
        audio_pkg::OFF_FORMAT:  format_next = pwdata[audio_pkg::FMT_W-1:0];
        audio_pkg::OFF_LOOP:    loop_next = pwdata[0];
        // any trigger write starts; set wins over done
        audio_pkg::OFF_TRIGGER: begin
          effectStart_next = 1'b1;
          effectBusy_next  = 1'b1;
          effectCode_next  = select_reg[audio_pkg::CODE_W-1:0];
          effectNote_next  = (select_reg[audio_pkg::CODE_W-1:0] < PITCH_LIMIT)
                           ? select_reg[audio_pkg::SEL_W-1:audio_pkg::NOTE_LSB]
                           : '0;
        end
        default: begin
        end
      endcase
    end
  end

  // playback fetch engine
  always_comb begin
    state_next   = state_reg;
    memAddr_next = memAddr_reg;
    remain_next  = remain_reg;
    readPtr_next = readPtr_reg;
    unique case (state_reg)
      audio_pkg::PB_IDLE: begin
      end
      audio_pkg::PB_FETCH: begin
        if (fetchHit) begin
          readPtr_next = memAddr_reg;
          memAddr_next = PW'(memAddr_reg + audio_pkg::WORD_BYTES);
          remain_next  = PW'(remain_reg - audio_pkg::WORD_BYTES);
          if (lastWord) begin
            if (loop_reg) begin
              memAddr_next = startAddr_reg;
              remain_next  = length_reg;
            end else begin
              state_next = audio_pkg::PB_DRAIN;
            end
          end
        end
      end
      audio_pkg::PB_DRAIN: begin
        // done only once the output has taken every word
        if (fifoEmpty) begin
          state_next = audio_pkg::PB_IDLE;
        end
      end
    endcase
    if (wrAcc && paddr == audio_pkg::OFF_PLAY) begin
      memAddr_next = startAddr_reg;
      remain_next  = length_reg;
      state_next   = (length_reg == '0) ? audio_pkg::PB_DRAIN : audio_pkg::PB_FETCH;
    end
    // one request outstanding, so an ack can never meet a full fifo
    memReq_next = (state_next == audio_pkg::PB_FETCH) && fifoInReady && !fetchHit;
  end

  sample_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (fetchHit),
    .inReady  (fifoInReady),
    .inData   (memData),
    .outValid (sampleValid),
    .outReady (sampleReady),
    .outData  (sampleData),
    .isEmpty  (fifoEmpty)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg      <= '0;
      pready_reg      <= 1'b0;
      pslverr_reg     <= 1'b0;
      select_reg      <= audio_pkg::SEL_RST;
      effectBusy_reg  <= 1'b0;
      effectStart_reg <= 1'b0;
      effectCode_reg  <= '0;
      effectNote_reg  <= '0;
      synVol_reg      <= audio_pkg::VOL_RST;
      pbVol_reg       <= audio_pkg::VOL_RST;
      startAddr_reg   <= '0;
      length_reg      <= '0;
      readPtr_reg     <= '0;
      rate_reg        <= audio_pkg::RATE_RST;
      format_reg      <= audio_pkg::FMT_LINEAR;
      loop_reg        <= 1'b0;
      state_reg       <= audio_pkg::PB_IDLE;
      memReq_reg      <= 1'b0;
      memAddr_reg     <= '0;
      remain_reg      <= '0;
    end else begin
      prdata_reg      <= prdata_next;
      pready_reg      <= pready_next;
      pslverr_reg     <= pslverr_next;
      select_reg      <= select_next;
      effectBusy_reg  <= effectBusy_next;
      effectStart_reg <= effectStart_next;
      effectCode_reg  <= effectCode_next;
      effectNote_reg  <= effectNote_next;
      synVol_reg      <= synVol_next;
      pbVol_reg       <= pbVol_next;
      startAddr_reg   <= startAddr_next;
      length_reg      <= length_next;
      readPtr_reg     <= readPtr_next;
      rate_reg        <= rate_next;
      format_reg      <= format_next;
      loop_reg        <= loop_next;
      state_reg       <= state_next;
      memReq_reg      <= memReq_next;
      memAddr_reg     <= memAddr_next;
      remain_reg      <= remain_next;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign effectStart  = effectStart_reg;
  assign effectCode   = effectCode_reg;
  assign effectNote   = effectNote_reg;
  assign synthGain    = synVol_reg;
  assign memReq       = memReq_reg;
  assign memAddr      = memAddr_reg;
  assign sampleFormat = format_reg;
  assign sampleRate   = rate_reg;
  assign playGain     = pbVol_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_trig_starts_fx: assert property (
    wrAcc && paddr == audio_pkg::OFF_TRIGGER |=> effectStart && effectBusy_reg ##1 !effectStart)
    else $error("trigger write did not start effect");
  a_busy_readback: assert property (
    setup && paddr == audio_pkg::OFF_TRIGGER |=> pready && prdata[0] == $past(effectBusy_reg))
    else $error("trigger readback wrong");
  a_fields_split: assert property (
    wrAcc && paddr == audio_pkg::OFF_TRIGGER && select_reg[7:0] < PITCH_LIMIT
    |=> effectNote == $past(select_reg[15:8]) && effectCode == $past(select_reg[7:0]))
    else $error("note or code field wrong");
  a_note_ignored: assert property (
    effectStart && effectCode >= PITCH_LIMIT |-> effectNote == '0)
    else $error("unpitched effect got a note");
  a_synth_gain: assert property (
    wrAcc && paddr == audio_pkg::OFF_SYN_VOL |=> synthGain == $past(pwdata[7:0]))
    else $error("synth gain not written");
  a_play_gain: assert property (
    wrAcc && paddr == audio_pkg::OFF_PB_VOL |=> playGain == $past(pwdata[7:0]))
    else $error("playback gain not written");
  a_play_begins: assert property (
    wrAcc && paddr == audio_pkg::OFF_PLAY && length_reg != '0
    |=> state_reg == audio_pkg::PB_FETCH && memAddr == $past(startAddr_reg))
    else $error("playback did not begin");
  a_done_drained: assert property (
    state_reg != audio_pkg::PB_IDLE ##1 state_reg == audio_pkg::PB_IDLE |-> $past(fifoEmpty))
    else $error("playback ended with data left");
  a_loop_restart: assert property (
    state_reg == audio_pkg::PB_FETCH && fetchHit && lastWord && loop_reg && !wrAcc
    |=> memAddr == $past(startAddr_reg) && state_reg == audio_pkg::PB_FETCH)
    else $error("loop did not restart");
  a_rdptr_follows: assert property (
    state_reg == audio_pkg::PB_FETCH && fetchHit |=> readPtr_reg == $past(memAddr_reg))
    else $error("read pointer not updated");
  a_reserved_zero: assert property (
    pready && !pslverr |-> prdata[31:20] == '0)
    else $error("reserved bits not zero");

  c_effect_run: cover property (effectStart ##[1:50] synthDone);
  c_play_done: cover property (state_reg == audio_pkg::PB_DRAIN ##[1:100] state_reg == audio_pkg::PB_IDLE);
  c_loop_wrap: cover property (fetchHit && lastWord && loop_reg);
endmodule : audio_engine_control

// >>> sim/tb.sv
// self-checking bench of the audio engine register front end
`timescale 1ns/1ps
module tb;
  // clock, reset and counters
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  int          err_total = 0;
  int          checked   = 0;
  int          seed      = 22;
  int          cycles    = 0;
  // apb
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // synthesizer, memory and output stage
  logic        effectStart;
  logic [7:0]  effectCode;
  logic [7:0]  effectNote;
  logic [7:0]  synthGain;
  logic        synthDone   = 1'b0;
  logic        memReq;
  logic [19:0] memAddr;
  logic        memAck      = 1'b0;
  logic [31:0] memData     = 32'h0;
  logic        sampleValid;
  logic        sampleReady = 1'b0;
  logic [31:0] sampleData;
  logic [1:0]  sampleFormat;
  logic [15:0] sampleRate;
  logic [7:0]  playGain;
  // bench state
  logic        stall    = 1'b0;
  int          ackCount = 0;
  int          pbIdx    = 0;
  int          pbWords  = 1;
  logic [19:0] pbStart  = 20'h0;
  logic [31:0] rdv;
  logic [31:0] v;
  logic        erv;
  logic [7:0]  ra [11] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'hB4, 8'hB8, 8'hBC, 8'hC0,
                           8'hC4, 8'hC8, 8'hCC};
  logic [31:0] rv [11] = '{32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F40,
                           32'h0, 32'h0, 32'h0};

  audio_engine_control #(.PITCH_LIMIT(8'h40), .FIFO_DEPTH(8)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .effectStart(effectStart), .effectCode(effectCode), .effectNote(effectNote),
    .synthGain(synthGain), .synthDone(synthDone), .memReq(memReq), .memAddr(memAddr),
    .memAck(memAck), .memData(memData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData), .sampleFormat(sampleFormat),
    .sampleRate(sampleRate), .playGain(playGain)
  );

  always #2 core_clk = ~core_clk;

  // cut a hang short well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  // memory with random latency; data off-ack toggles so stale data never matches
  always @(posedge core_clk) begin
    if (memReq === 1'b1 && memAck === 1'b0 && ($random(seed) & 3) == 0) begin
      memAck  <= 1'b1;
      memData <= {12'hC3C, memAddr};
      ackCount++;
    end else begin
      memAck  <= 1'b0;
      memData <= ~memData;
    end
  end

  // output stage stalls at random, or fully while stall is set
  always @(posedge core_clk) begin
    if (sampleValid === 1'b1 && sampleReady === 1'b1) begin
      chk_word("sampleData", exp_sample(pbIdx), sampleData);
      pbIdx++;
    end
    sampleReady <= !stall && (($random(seed) & 1) == 1);
  end

  function automatic logic [31:0] exp_sample(input int idx);
    return {12'hC3C, pbStart + 20'(4 * (idx % pbWords))};
  endfunction : exp_sample

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word("register", exp, rdv);
    chk_flag("pslverr", 1'b0, erv);
  endtask : rdc

  task automatic effect(input logic [7:0] code, input logic [7:0] note, input logic [31:0] t);
    apb(1'b1, 8'h88, {16'h0, note, code});
    apb(1'b1, 8'h8C, t);
    #1;
    chk_flag("effectStart", 1'b1, effectStart);
    chk_word("effectCode", 32'(code), 32'(effectCode));
    chk_word("effectNote", (code < 8'h40) ? 32'(note) : 32'h0, 32'(effectNote));
    @(posedge core_clk);
    #1;
    chk_flag("effectStart", 1'b0, effectStart);
    rdc(8'h8C, 32'h1);
    @(posedge core_clk);
    synthDone <= 1'b1;
    @(posedge core_clk);
    synthDone <= 1'b0;
    rdc(8'h8C, 32'h0);
  endtask : effect

  task automatic play(input logic [19:0] s, input logic [31:0] len, input logic lp,
                      input logic [31:0] t);
    apb(1'b1, 8'hB4, 32'(s));
    apb(1'b1, 8'hB8, len);
    apb(1'b1, 8'hC8, 32'(lp));
    pbStart  = s;
    pbWords  = (len + 3) / 4;
    pbIdx    = 0;
    ackCount = 0;
    apb(1'b1, 8'hCC, t);
  endtask : play

  // status bit must clear only once every sample has left the block
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'hCC, 32'h0);
      k++;
    end while (rdv !== 32'h0 && k < 400);
    chk_word("playStatus", 32'h0, rdv);
  endtask : wait_idle

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk_word("synthGain", 32'hFF, 32'(synthGain));
    chk_word("playGain", 32'hFF, 32'(playGain));
    chk_word("sampleRate", 32'h1F40, 32'(sampleRate));
    for (int i = 0; i < 11; i++) rdc(ra[i], rv[i]);
    apb(1'b0, 8'h00, 32'h0);
    chk_flag("pslverr", 1'b1, erv);
    chk_word("prdata", 32'h0, rdv);
    // unmapped write is refused and leaves the synth volume alone
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    chk_flag("pslverr", 1'b1, erv);
    rdc(8'h84, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hFFFFFF00 : $random(seed);
      apb(1'b1, 8'h84, v);
      apb(1'b1, 8'h80, ~v);
      rdc(8'h84, v & 32'hFF);
      rdc(8'h80, ~v & 32'hFF);
      chk_word("synthGain", v & 32'hFF, 32'(synthGain));
      chk_word("playGain", ~v & 32'hFF, 32'(playGain));
      apb(1'b1, 8'hC0, v);
      rdc(8'hC0, v & 32'hFFFF);
      chk_word("sampleRate", v & 32'hFFFF, 32'(sampleRate));
      apb(1'b1, 8'hC4, 32'hFFFFFFFC | i);
      rdc(8'hC4, 32'(i));
      chk_word("sampleFormat", 32'(i), 32'(sampleFormat));
    end
    apb(1'b1, 8'hC4, 32'h0);
    apb(1'b1, 8'h88, 32'hFFFFFFFF);
    rdc(8'h88, 32'h0000FFFF);
    apb(1'b1, 8'hBC, 32'hFFFFFFFF);
    rdc(8'hBC, 32'h0);
    effect(8'h3F, 8'h5A, 32'h0);
    effect(8'h40, 8'hA5, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      effect(8'($random(seed)), 8'($random(seed)), $random(seed));
    end
    effect(8'h00, 8'h00, 32'h1);
    // full stall: fetching must stop once the buffer is full
    stall = 1'b1;
    play(20'h01000, 32'd45, 1'b0, 32'h0);
    repeat (120) @(posedge core_clk);
    #1;
    chk_flag("memReq", 1'b0, memReq);
    // eight buffered words plus the output register
    chk_word("ackCount", 32'd9, 32'(ackCount));
    rdc(8'hCC, 32'h1);
    rdc(8'hBC, 32'(20'h01000 + 20'(4 * (ackCount - 1))));
    stall = 1'b0;
    wait_idle();
    chk_word("sampleCount", 32'd12, 32'(pbIdx));
    rdc(8'hBC, 32'h0102C);
    play(20'h02000, 32'd8, 1'b1, 32'h1);
    for (int k = 0; k < 3000 && pbIdx < 5; k++) @(posedge core_clk);
    chk_flag("looped", 1'b1, pbIdx >= 5);
    apb(1'b1, 8'hC8, 32'h0);
    wait_idle();
    rdc(8'hBC, 32'h02004);
    // zero length finishes at once without a single fetch
    play(20'h03000, 32'd0, 1'b0, 32'h0);
    wait_idle();
    chk_word("sampleCount", 32'd0, 32'(pbIdx));
    chk_word("ackCount", 32'd0, 32'(ackCount));
    report_and_stop();
  end
endmodule : tb
